//--- pttpl_cfg.svh
`ifndef PTTPL_CFG_SVH
`define PTTPL_CFG_SVH
`define PT_CLK_HZ 32'h02625A00
`define PT_SEC_NS 32'h3B9ACA00
`define PT_HALF_NS 32'h1DCD6500
`define PT_NS_CLK (`PT_SEC_NS / `PT_CLK_HZ)
`define PT_PPS_W_NS 32'h00002710
`define PT_PPS_CYC (`PT_PPS_W_NS / `PT_NS_CLK)
`define PT_WIN_NS 32'h000003E8
`define PT_LED_NS 32'h042C1D80
`define PT_LOSS_NS 32'h5F5E1000
`define PT_BAUD 32'h00002580
`define PT_SYNC_PULSES 9'h12C
`define PT_FMAX 32'h000007D0
`define PT_TRIM_MID 13'h0800
`define PT_A_CTRL 3'h0
`define PT_A_OFFS 3'h1
`define PT_A_STAT 3'h2
`define PT_A_TAG 3'h3
`define PT_A_FREQ 3'h4
`define PT_A_NVOF 3'h5
`define PT_CTRL_RST 6'h23
`define PT_CH_CR 8'h0D
`define PT_CH_Q 8'h3F
`define PT_CH_BANG 8'h21
`define PT_CH_MINUS 8'h2D
`define PT_CH_0 8'h30
`define PT_CH_9 8'h39
`define PT_CMD_FREQ 16'h5346
`define PT_CMD_TAG 16'h5454
`define PT_CMD_OFFS 16'h544F
`define PT_CMD_PF 16'h4C4D
`define PT_CMD_TC 16'h5054
`define PT_CMD_LOCK 16'h504C
`endif

//--- pttpl_pkg.sv
package pttpl_pkg;
  typedef enum logic [3:0] {
    PS_IDLE = 4'b0001,
    PS_EXEC = 4'b0010,
    PS_CONV = 4'b0100,
    PS_SEND = 4'b1000
  } pttpl_state_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } pttpl_byte_t;
  typedef struct packed {
    logic [3:0] tc;
    logic prefilt;
    logic lock_en;
  } pttpl_ctrl_t;
endpackage

//--- pttpl_uart_rx.sv
`timescale 1ns/1ps
module pttpl_uart_rx
  import pttpl_pkg::*;
#(
  parameter int DIV = 4166
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic rxd,
  output pttpl_byte_t rx_o
);
  logic busy_ff, nxt_busy;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [3:0] bit_ff, nxt_bit;
  logic [7:0] sh_ff, nxt_sh;
  pttpl_byte_t out_ff, nxt_out;

  always_comb
  begin
    nxt_busy = busy_ff;
    nxt_cnt = cnt_ff;
    nxt_bit = bit_ff;
    nxt_sh = sh_ff;
    nxt_out = '{valid: 1'b0, data: out_ff.data};
    if (!busy_ff)
    begin
      if (!rxd)
      begin
        nxt_busy = 1'b1;
        nxt_cnt = 16'(DIV / 2);
        nxt_bit = 4'h0;
      end
    end
    else if (cnt_ff != 16'h0)
      nxt_cnt = cnt_ff - 16'h1;
    else
    begin
      nxt_cnt = 16'(DIV - 1);
      nxt_bit = bit_ff + 4'h1;
      if (bit_ff == 4'h0 && rxd)
        nxt_busy = 1'b0;
      else if (bit_ff == 4'h9)
      begin
        nxt_busy = 1'b0;
        nxt_out = '{valid: rxd, data: sh_ff};
      end
      else if (bit_ff != 4'h0)
        nxt_sh = {rxd, sh_ff[7:1]};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      busy_ff <= 1'b0;
      cnt_ff <= 16'h0;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      out_ff <= '0;
    end
    else if (clk_en)
    begin
      busy_ff <= nxt_busy;
      cnt_ff <= nxt_cnt;
      bit_ff <= nxt_bit;
      sh_ff <= nxt_sh;
      out_ff <= nxt_out;
    end
  end

  assign rx_o = out_ff;
endmodule

//--- pttpl_uart_tx.sv
`timescale 1ns/1ps
module pttpl_uart_tx
  import pttpl_pkg::*;
#(
  parameter int DIV = 4166
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input pttpl_byte_t tx_i,
  output logic tx_ready,
  output logic txd
);
  logic busy_ff, nxt_busy;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [3:0] bit_ff, nxt_bit;
  logic [9:0] sh_ff, nxt_sh;

  always_comb
  begin
    nxt_busy = busy_ff;
    nxt_cnt = cnt_ff;
    nxt_bit = bit_ff;
    nxt_sh = sh_ff;
    if (!busy_ff)
    begin
      if (tx_i.valid)
      begin
        nxt_busy = 1'b1;
        nxt_sh = {1'b1, tx_i.data, 1'b0};
        nxt_cnt = 16'(DIV - 1);
        nxt_bit = 4'h0;
      end
    end
    else if (cnt_ff != 16'h0)
      nxt_cnt = cnt_ff - 16'h1;
    else
    begin
      nxt_cnt = 16'(DIV - 1);
      nxt_sh = {1'b1, sh_ff[9:1]};
      nxt_bit = bit_ff + 4'h1;
      if (bit_ff == 4'h9)
        nxt_busy = 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      busy_ff <= 1'b0;
      cnt_ff <= 16'h0;
      bit_ff <= 4'h0;
      sh_ff <= 10'h3FF;
    end
    else if (clk_en)
    begin
      busy_ff <= nxt_busy;
      cnt_ff <= nxt_cnt;
      bit_ff <= nxt_bit;
      sh_ff <= nxt_sh;
    end
  end

  assign tx_ready = !busy_ff;
  assign txd = sh_ff[0];
endmodule

//--- pttpl_top.sv
`timescale 1ns/1ps
`include "pttpl_cfg.svh"
// How it works
// - Capture local nanosecond count at each external pulse rising edge.
// - Input late by N ns reports N.
// - Input early wraps modulo one second, e.g. 999999995.
// - Tag query before any capture replies minus one.
// - Signed offset added to every raw capture before reporting.
// - Save copies offset to nonvolatile copy; separate query reads it.
// - Without input pulses, frequency setting follows the trim input.
// - Detected pulses hand the frequency setting to the loop.
// - Reset, or lock enable 0, returns the frequency setting to the trim input.
// - Frequency setting query replies a signed value within 2000.
// - Proportional-integral loop driven by the nanosecond phase error.
// - Prefilter select 1 smooths phase errors; default is 1.
// - Loop time constant defaults to 8, the slow setting.
// - Lock enable 0 stops locking; query then replies 0.
// - Input lamp flashes per pulse; sync lamp after 300 aligned pulses.
// - Serial link at 9600 baud; code, signed value or question mark.
// - Every reply ends with a carriage return.
// - Tag query returns the last stored capture, not a new one.
module pttpl_top
  import pttpl_pkg::*;
#(
  parameter int LED_CYC = `PT_LED_NS / `PT_NS_CLK,
  parameter int LOSS_CYC = `PT_LOSS_NS / `PT_NS_CLK,
  parameter int BAUD_DIV = `PT_CLK_HZ / `PT_BAUD
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic pps_in,
  input wire logic ser_rx_in,
  input wire logic [11:0] frequency_trim_input,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic pps_out,
  output logic ser_tx_out,
  output logic input_led,
  output logic sync_led,
  output logic [11:0] frequency_setting
);
  function automatic logic [11:0] clamp_f(input logic signed [31:0] v);
    if (v > $signed(`PT_FMAX))
      return 12'(`PT_FMAX);
    else if (v < -$signed(`PT_FMAX))
      return 12'(-$signed(`PT_FMAX));
    else
      return v[11:0];
  endfunction

  function automatic logic [31:0] pow10_f(input logic [3:0] i);
    case (i)
      4'h0: return 32'h00000001;
      4'h1: return 32'h0000000A;
      4'h2: return 32'h00000064;
      4'h3: return 32'h000003E8;
      4'h4: return 32'h00002710;
      4'h5: return 32'h000186A0;
      4'h6: return 32'h000F4240;
      4'h7: return 32'h00989680;
      4'h8: return 32'h05F5E100;
      default: return `PT_SEC_NS;
    endcase
  endfunction

  // Pin synchronisers, pps in bit 0, serial in bit 1
  logic [1:0] s1_ff, s2_ff, s3_ff, cln_ff, nxt_cln;
  logic ppd_ff, cap;
  always_comb
  begin
    nxt_cln = ((s2_ff ~^ s3_ff) & s2_ff) | (~(s2_ff ~^ s3_ff) & cln_ff);
    cap = cln_ff[0] && !ppd_ff;
  end

  // Local second counter and pulse
  logic [29:0] ns_ff, nxt_ns;
  logic [30:0] nsum;
  logic wrap;
  logic [8:0] pcnt_ff, nxt_pcnt;
  logic pps_ff, nxt_pps;
  always_comb
  begin
    nsum = {1'b0, ns_ff} + 31'(`PT_NS_CLK);
    wrap = nsum >= 31'(`PT_SEC_NS);
    nxt_ns = wrap ? 30'(nsum - 31'(`PT_SEC_NS)) : nsum[29:0];
    nxt_pps = wrap || (pcnt_ff != 9'h0);
    nxt_pcnt = wrap ? 9'(`PT_PPS_CYC - 1)
             : (pcnt_ff != 9'h0 ? pcnt_ff - 9'h1 : 9'h0);
  end

  // Parameters, bus and serial writes
  pttpl_ctrl_t ctrl_ff, nxt_ctrl;
  logic signed [31:0] offs_ff, nxt_offs, nv_ff, nxt_nv;
  logic wait_ff, nxt_wait, acc;
  logic [31:0] rd_ff, nxt_rd;
  logic s_we;
  logic [15:0] s_code;
  logic signed [31:0] s_val;
  logic s_save;
  logic tag_val_ff, pll_on_ff;
  logic [29:0] tag_res_ff;
  logic [11:0] freq_ff;
  logic sync_ff;
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_offs = offs_ff;
    nxt_nv = nv_ff;
    nxt_rd = rd_ff;
    acc = (avs_read || avs_write) && !wait_ff;
    nxt_wait = !((avs_read || avs_write) && wait_ff);
    if ((avs_read || avs_write) && wait_ff)
    begin
      if (avs_address == `PT_A_CTRL)
        nxt_rd = {26'h0, ctrl_ff};
      else if (avs_address == `PT_A_OFFS)
        nxt_rd = offs_ff;
      else if (avs_address == `PT_A_STAT)
        nxt_rd = {29'h0, sync_ff, pll_on_ff, tag_val_ff};
      else if (avs_address == `PT_A_TAG)
        nxt_rd = tag_val_ff ? {2'b00, tag_res_ff} : 32'hFFFFFFFF;
      else if (avs_address == `PT_A_FREQ)
        nxt_rd = {{20{freq_ff[11]}}, freq_ff};
      else if (avs_address == `PT_A_NVOF)
        nxt_rd = nv_ff;
      else
        nxt_rd = 32'h0;
    end
    if (acc && avs_write)
    begin
      if (avs_address == `PT_A_CTRL)
        nxt_ctrl = avs_writedata[5:0];
      else if (avs_address == `PT_A_OFFS)
        nxt_offs = avs_writedata;
      else if (avs_address == `PT_A_NVOF)
        nxt_nv = offs_ff;
    end
    else if (s_save)
      nxt_nv = offs_ff;
    else if (s_we)
    begin
      if (s_code == `PT_CMD_OFFS)
        nxt_offs = s_val;
      else if (s_code == `PT_CMD_PF)
        nxt_ctrl.prefilt = s_val[0];
      else if (s_code == `PT_CMD_TC)
        nxt_ctrl.tc = s_val[3:0];
      else if (s_code == `PT_CMD_LOCK)
        nxt_ctrl.lock_en = s_val[0];
    end
  end

  // Capture, loop and lamps
  logic [29:0] tag_raw_ff, nxt_raw, nxt_res;
  logic nxt_tval, nxt_pon, nxt_sync, inwin;
  logic signed [32:0] rsum;
  logic signed [31:0] err, filt_ff, nxt_filt, integ_ff, nxt_integ;
  logic [11:0] nxt_freq, trim_f;
  logic [12:0] trim_d;
  logic [8:0] scnt_ff, nxt_scnt;
  logic [25:0] gap_ff, nxt_gap;
  logic [21:0] led_ff, nxt_led;
  logic led_o_ff, nxt_led_o;
  always_comb
  begin
    nxt_raw = tag_raw_ff;
    nxt_res = tag_res_ff;
    nxt_tval = tag_val_ff;
    nxt_pon = pll_on_ff;
    nxt_filt = filt_ff;
    nxt_integ = integ_ff;
    rsum = $signed({3'b000, ns_ff}) + $signed({offs_ff[31], offs_ff});
    if (rsum < 0)
      rsum = rsum + $signed({1'b0, `PT_SEC_NS});
    else if (rsum >= $signed({1'b0, `PT_SEC_NS}))
      rsum = rsum - $signed({1'b0, `PT_SEC_NS});
    err = (ns_ff >= 30'(`PT_HALF_NS)) ? $signed({2'b00, ns_ff}) - $signed(`PT_SEC_NS)
          : $signed({2'b00, ns_ff});
    inwin = ({2'b00, ns_ff} < `PT_WIN_NS)
         || ({2'b00, ns_ff} > `PT_SEC_NS - `PT_WIN_NS);
    nxt_scnt = scnt_ff;
    nxt_gap = (gap_ff < 26'(LOSS_CYC)) ? gap_ff + 26'h1 : gap_ff;
    nxt_led = (led_ff != 22'h0) ? led_ff - 22'h1 : 22'h0;
    if (gap_ff >= 26'(LOSS_CYC))
      nxt_scnt = 9'h0;
    if (cap)
    begin
      nxt_raw = ns_ff;
      nxt_res = rsum[29:0];
      nxt_tval = 1'b1;
      nxt_gap = 26'h0;
      nxt_led = 22'(LED_CYC);
      nxt_scnt = inwin ? (scnt_ff < `PT_SYNC_PULSES ? scnt_ff + 9'h1 : scnt_ff)
               : 9'h0;
      if (ctrl_ff.lock_en)
      begin
        nxt_pon = 1'b1;
        nxt_filt = ctrl_ff.prefilt ? filt_ff + ((err - filt_ff) >>> 2) : err;
        nxt_integ = integ_ff + (nxt_filt >>> ctrl_ff.tc);
      end
    end
    nxt_led_o = nxt_led != 22'h0;
    nxt_sync = nxt_scnt == `PT_SYNC_PULSES;
    trim_d = {1'b0, frequency_trim_input} - `PT_TRIM_MID;
    trim_f = clamp_f({{19{trim_d[12]}}, trim_d});
    if (pll_on_ff && ctrl_ff.lock_en)
      nxt_freq = clamp_f(-((integ_ff >>> 4) + (filt_ff >>> ctrl_ff.tc)));
    else
      nxt_freq = trim_f;
  end

  // Serial command parser and reply formatter
  pttpl_byte_t rx_b, tx_b;
  logic tx_rdy;
  pttpl_state_t st_ff, nxt_st;
  logic [15:0] code_ff, nxt_code;
  logic q_ff, nxt_q, b_ff, nxt_b, n_ff, nxt_n;
  logic [31:0] acc_ff, nxt_acc, rval_ff, nxt_rval;
  logic rneg_ff, nxt_rneg, strt_ff, nxt_strt, last_ff, nxt_last;
  logic [3:0] idx_ff, nxt_idx, dig_ff, nxt_dig;
  logic [7:0] ch_ff, nxt_ch;
  logic rep;
  logic signed [31:0] rv;
  always_comb
  begin
    nxt_st = st_ff;
    nxt_code = code_ff;
    nxt_q = q_ff;
    nxt_b = b_ff;
    nxt_n = n_ff;
    nxt_acc = acc_ff;
    nxt_rval = rval_ff;
    nxt_rneg = rneg_ff;
    nxt_strt = strt_ff;
    nxt_last = last_ff;
    nxt_idx = idx_ff;
    nxt_dig = dig_ff;
    nxt_ch = ch_ff;
    tx_b = '{valid: 1'b0, data: ch_ff};
    s_we = 1'b0;
    s_save = 1'b0;
    s_code = code_ff;
    s_val = n_ff ? -$signed(acc_ff) : $signed(acc_ff);
    rep = q_ff;
    rv = 32'sh0;
    case (st_ff)
      PS_IDLE:
        if (rx_b.valid)
        begin
          if (rx_b.data == `PT_CH_CR)
            nxt_st = PS_EXEC;
          else if (rx_b.data == `PT_CH_Q)
            nxt_q = 1'b1;
          else if (rx_b.data == `PT_CH_BANG)
            nxt_b = 1'b1;
          else if (rx_b.data == `PT_CH_MINUS)
            nxt_n = 1'b1;
          else if (rx_b.data >= `PT_CH_0 && rx_b.data <= `PT_CH_9)
            nxt_acc = 32'(acc_ff * 32'h0000000A)
                    + {24'h0, rx_b.data - `PT_CH_0};
          else
            nxt_code = {code_ff[7:0], rx_b.data};
        end
      PS_EXEC:
      begin
        if (code_ff == `PT_CMD_FREQ)
          rv = {{20{freq_ff[11]}}, freq_ff};
        else if (code_ff == `PT_CMD_TAG)
          rv = tag_val_ff ? $signed({2'b00, tag_res_ff}) : -32'sh1;
        else if (code_ff == `PT_CMD_OFFS)
          rv = b_ff ? nv_ff : offs_ff;
        else if (code_ff == `PT_CMD_PF)
          rv = {31'h0, ctrl_ff.prefilt};
        else if (code_ff == `PT_CMD_TC)
          rv = {28'h0, ctrl_ff.tc};
        else if (code_ff == `PT_CMD_LOCK)
          rv = {31'h0, ctrl_ff.lock_en};
        else
          rep = 1'b0;
        s_save = !q_ff && b_ff && code_ff == `PT_CMD_OFFS;
        s_we = !q_ff && !b_ff;
        nxt_code = 16'h0;
        nxt_q = 1'b0;
        nxt_b = 1'b0;
        nxt_n = 1'b0;
        nxt_acc = 32'h0;
        nxt_rneg = rv < 0;
        nxt_rval = rv < 0 ? 32'(-rv) : rv;
        nxt_idx = 4'h9;
        nxt_dig = 4'h0;
        nxt_strt = 1'b0;
        nxt_last = 1'b0;
        nxt_ch = `PT_CH_MINUS;
        nxt_st = !rep ? PS_IDLE : (rv < 0 ? PS_SEND : PS_CONV);
      end
      PS_CONV:
        if (rval_ff >= pow10_f(idx_ff))
        begin
          nxt_rval = rval_ff - pow10_f(idx_ff);
          nxt_dig = dig_ff + 4'h1;
        end
        else
        begin
          nxt_dig = 4'h0;
          nxt_idx = (idx_ff != 4'h0) ? idx_ff - 4'h1 : 4'h0;
          if (strt_ff || dig_ff != 4'h0 || idx_ff == 4'h0)
          begin
            nxt_ch = `PT_CH_0 + {4'h0, dig_ff};
            nxt_strt = 1'b1;
            nxt_last = idx_ff == 4'h0;
            nxt_st = PS_SEND;
          end
        end
      PS_SEND:
        if (tx_rdy)
        begin
          tx_b.valid = 1'b1;
          if (ch_ff == `PT_CH_CR)
            nxt_st = PS_IDLE;
          else if (last_ff)
            nxt_ch = `PT_CH_CR;
          else
            nxt_st = PS_CONV;
        end
      default:
        nxt_st = PS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      s1_ff <= 2'b10;
      s2_ff <= 2'b10;
      s3_ff <= 2'b10;
      cln_ff <= 2'b10;
      ppd_ff <= 1'b0;
      ns_ff <= 30'h0;
      pcnt_ff <= 9'h0;
      pps_ff <= 1'b0;
      ctrl_ff <= `PT_CTRL_RST;
      offs_ff <= 32'sh0;
      nv_ff <= 32'sh0;
      wait_ff <= 1'b1;
      rd_ff <= 32'h0;
      tag_raw_ff <= 30'h0;
      tag_res_ff <= 30'h0;
      tag_val_ff <= 1'b0;
      pll_on_ff <= 1'b0;
      filt_ff <= 32'sh0;
      integ_ff <= 32'sh0;
      freq_ff <= 12'h0;
      scnt_ff <= 9'h0;
      gap_ff <= 26'h0;
      led_ff <= 22'h0;
      led_o_ff <= 1'b0;
      sync_ff <= 1'b0;
      st_ff <= PS_IDLE;
      code_ff <= 16'h0;
      q_ff <= 1'b0;
      b_ff <= 1'b0;
      n_ff <= 1'b0;
      acc_ff <= 32'h0;
      rval_ff <= 32'h0;
      rneg_ff <= 1'b0;
      strt_ff <= 1'b0;
      last_ff <= 1'b0;
      idx_ff <= 4'h0;
      dig_ff <= 4'h0;
      ch_ff <= 8'h00;
    end
    else if (clk_en)
    begin
      s1_ff <= {ser_rx_in, pps_in};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      cln_ff <= nxt_cln;
      ppd_ff <= cln_ff[0];
      ns_ff <= nxt_ns;
      pcnt_ff <= nxt_pcnt;
      pps_ff <= nxt_pps;
      ctrl_ff <= nxt_ctrl;
      offs_ff <= nxt_offs;
      nv_ff <= nxt_nv;
      wait_ff <= nxt_wait;
      rd_ff <= nxt_rd;
      tag_raw_ff <= nxt_raw;
      tag_res_ff <= nxt_res;
      tag_val_ff <= nxt_tval;
      pll_on_ff <= nxt_pon;
      filt_ff <= nxt_filt;
      integ_ff <= nxt_integ;
      freq_ff <= nxt_freq;
      scnt_ff <= nxt_scnt;
      gap_ff <= nxt_gap;
      led_ff <= nxt_led;
      led_o_ff <= nxt_led_o;
      sync_ff <= nxt_sync;
      st_ff <= nxt_st;
      code_ff <= nxt_code;
      q_ff <= nxt_q;
      b_ff <= nxt_b;
      n_ff <= nxt_n;
      acc_ff <= nxt_acc;
      rval_ff <= nxt_rval;
      rneg_ff <= nxt_rneg;
      strt_ff <= nxt_strt;
      last_ff <= nxt_last;
      idx_ff <= nxt_idx;
      dig_ff <= nxt_dig;
      ch_ff <= nxt_ch;
    end
  end

  pttpl_uart_rx #(.DIV(BAUD_DIV)) u_rx (.ref_clk(ref_clk),
    .reset_n(reset_n), .clk_en(clk_en), .rxd(cln_ff[1]), .rx_o(rx_b));
  pttpl_uart_tx #(.DIV(BAUD_DIV)) u_tx (.ref_clk(ref_clk),
    .reset_n(reset_n), .clk_en(clk_en), .tx_i(tx_b), .tx_ready(tx_rdy),
    .txd(ser_tx_out));

  assign avs_readdata = rd_ff;
  assign avs_waitrequest = wait_ff;
  assign pps_out = pps_ff;
  assign input_led = led_o_ff;
  assign sync_led = sync_ff;
  assign frequency_setting = freq_ff;

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!reset_n || !clk_en);
  AST_CAPTURE: assert property (cap |=> tag_val_ff && tag_raw_ff == $past(ns_ff))
    else $error("capture missed");
  AST_OFFS0: assert property (cap && offs_ff == 0 |=> tag_res_ff == tag_raw_ff)
    else $error("zero offset changed tag");
  AST_WRAP: assert property (tag_res_ff < `PT_SEC_NS && ns_ff < `PT_SEC_NS)
    else $error("value beyond one second");
  AST_NOTAG: assert property (st_ff == PS_EXEC && code_ff == `PT_CMD_TAG && q_ff
    && !tag_val_ff |=> rneg_ff && rval_ff == 1)
    else $error("empty tag not minus one");
  AST_SAVE: assert property (acc && avs_write && avs_address == `PT_A_NVOF
    |=> nv_ff == $past(offs_ff))
    else $error("save lost");
  AST_TRIM: assert property (!(pll_on_ff && ctrl_ff.lock_en)
    |=> freq_ff == $past(trim_f))
    else $error("trim not followed");
  AST_TAKE: assert property (cap && ctrl_ff.lock_en |=> pll_on_ff)
    else $error("loop did not take over");
  AST_STICKY: assert property (pll_on_ff |=> pll_on_ff)
    else $error("loop released without reset");
  AST_RANGE: assert property ($signed(freq_ff) <= $signed(12'h7D0)
    && $signed(freq_ff) >= -$signed(12'h7D0))
    else $error("frequency out of range");
  AST_CR: assert property (tx_b.valid && ch_ff == `PT_CH_CR |=> st_ff == PS_IDLE)
    else $error("reply not closed");
  AST_PPS: assert property (wrap |=> pps_ff ##1 pps_ff)
    else $error("pulse not started");
  AST_BUS: assert property ((avs_read || avs_write) && wait_ff |=> !wait_ff ##1 wait_ff)
    else $error("bus answer timing");
  COV_CAP: cover property (cap ##1 tag_val_ff);
  COV_SYNC: cover property ($rose(sync_ff));
  COV_REPLY: cover property (st_ff == PS_SEND && tx_b.valid && ch_ff == `PT_CH_CR);
endmodule

//--- pttpl_partner.sv
`timescale 1ns/1ps
module pttpl_partner
#(
  parameter int DIV = 8
)
(
  input wire logic ref_clk,
  input wire logic ser_tx_out,
  output logic pps_in,
  output logic ser_rx_in
);
  int cyc = 0;
  initial
  begin
    pps_in = 1'b0;
    ser_rx_in = 1'b1;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;
  // rising edge at a chosen cycle
  task automatic pulse(input int at);
    while (cyc < at) @(posedge ref_clk);
    pps_in <= 1'b1;
    repeat (8) @(posedge ref_clk);
    pps_in <= 1'b0;
  endtask
  task automatic send(input string s);
    logic [9:0] f;
    s = {s, "\r"};
    for (int i = 0; i < s.len(); i++)
    begin
      f = {1'b1, s[i], 1'b0};
      for (int b = 0; b < 10; b++)
      begin
        @(posedge ref_clk);
        ser_rx_in <= f[b];
        repeat (DIV - 1) @(posedge ref_clk);
      end
    end
  endtask
  task automatic recv(output string r, output bit ok);
    logic [7:0] c;
    int t;
    r = "";
    ok = 1'b0;
    c = 8'h00;
    while (c != 8'h0D)
    begin
      t = 0;
      while (ser_tx_out !== 1'b0 && t < 400)
      begin
        @(posedge ref_clk);
        t++;
      end
      if (t >= 400)
        return;
      repeat (DIV + DIV / 2) @(posedge ref_clk);
      for (int b = 0; b < 8; b++)
      begin
        c[b] = ser_tx_out;
        repeat (DIV) @(posedge ref_clk);
      end
      if (c != 8'h0D)
        r = {r, string'(c)};
    end
    ok = 1'b1;
  endtask
endmodule

//--- pttpl_top_bench.sv
`timescale 1ns/1ps
`include "pttpl_cfg.svh"
module pttpl_top_bench import pttpl_pkg::*;;
  logic ref_clk, reset_n, pps_in, ser_rx_in, avs_read, avs_write;
  logic avs_waitrequest, pps_out, ser_tx_out, input_led, sync_led;
  logic [11:0] trim, frequency_setting;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, t0v;
  int n_fail = 0;
  int tests_run = 0;
  int sb, s1;
  pttpl_top #(.LED_CYC(20), .LOSS_CYC(2000), .BAUD_DIV(8)) dut_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'b1),
    .pps_in(pps_in), .ser_rx_in(ser_rx_in),
    .frequency_trim_input(trim), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pps_out(pps_out),
    .ser_tx_out(ser_tx_out), .input_led(input_led),
    .sync_led(sync_led), .frequency_setting(frequency_setting));
  pttpl_partner #(.DIV(8)) partner_u (
    .ref_clk(ref_clk), .ser_tx_out(ser_tx_out),
    .pps_in(pps_in), .ser_rx_in(ser_rx_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic av(input logic w, input logic [2:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic q(input string s, input string e);
    string r;
    bit ok;
    partner_u.send(s);
    partner_u.recv(r, ok);
    check({31'h0, ok && r == e}, 32'h1);
  endtask
  task automatic rst();
    reset_n <= 1'b0;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic t_def();
    logic [31:0] d;
    av(1'b0, `PT_A_CTRL, 32'h0, d);
    check(d, 32'h00000023);
    av(1'b0, `PT_A_TAG, 32'h0, d);
    check(d, 32'hFFFFFFFF);
    av(1'b0, `PT_A_NVOF, 32'h0, d);
    check(d, 32'h00000000);
    av(1'b0, 3'h6, 32'h0, d);
    check(d, 32'h00000000);
    check(frequency_setting, 12'h034);
    check(pps_out, 1'b0);
    check(sync_led, 1'b0);
    trim <= 12'hFFF;
    repeat (4) @(posedge ref_clk);
    check(frequency_setting, 12'h7D0);
    q("SF?", "2000");
    trim <= 12'h834;
    $display("Defaults test done");
  endtask
  task automatic t_ser();
    logic [31:0] d;
    q("TT?", "-1");
    q("LM?", "1");
    q("PT?", "8");
    partner_u.send("PL0");
    q("PL?", "0");
    av(1'b0, `PT_A_CTRL, 32'h0, d);
    check(d, 32'h00000022);
    partner_u.send("PL1");
    repeat (20) @(posedge ref_clk);
    $display("Serial test done");
  endtask
  task automatic t_tag();
    logic [31:0] d;
    sb = partner_u.cyc + 20;
    partner_u.pulse(sb);
    check(input_led, 1'b1);
    av(1'b0, `PT_A_TAG, 32'h0, t0v);
    av(1'b0, `PT_A_STAT, 32'h0, d);
    check(d[1:0], 2'b11);
    repeat (30) @(posedge ref_clk);
    check(input_led, 1'b0);
    s1 = partner_u.cyc + 20;
    partner_u.pulse(s1);
    av(1'b0, `PT_A_TAG, 32'h0, d);
    check(d, t0v + 32'(25 * (s1 - sb)));
    av(1'b1, `PT_A_OFFS, 32'h00000064, d);
    s1 = partner_u.cyc + 20;
    partner_u.pulse(s1);
    av(1'b0, `PT_A_TAG, 32'h0, d);
    check(d, t0v + 32'(25 * (s1 - sb)) + 32'h64);
    q("TO?", "100");
    partner_u.send("TO!");
    repeat (20) @(posedge ref_clk);
    av(1'b0, `PT_A_NVOF, 32'h0, d);
    check(d, 32'h00000064);
    q("TO!?", "100");
    s1 = partner_u.cyc + 60;
    d = 32'h0 - t0v - 32'(25 * (s1 - sb)) - 32'h5;
    av(1'b1, `PT_A_OFFS, d, d);
    partner_u.pulse(s1);
    av(1'b0, `PT_A_TAG, 32'h0, d);
    check(d, 32'h3B9AC9FB);
    $display("Tag test done");
  endtask
  task automatic t_rst();
    logic [31:0] d;
    rst();
    check(frequency_setting, 12'h034);
    av(1'b0, `PT_A_STAT, 32'h0, d);
    check(d[1], 1'b0);
    $display("Reset test done");
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    n_fail++;
    conclude();
  end
  initial
  begin
    reset_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 3'h0;
    avs_writedata = 32'h0;
    trim = 12'h834;
    rst();
    t_def();
    t_ser();
    t_tag();
    t_rst();
    conclude();
  end
endmodule
